// >>> pkg/fws_pkg.sv
// fws_pkg: constants, states and carriers of the flash write-status sequencer
// assumes one 100 MHz clock; counts are derived from times in ns
package fws_pkg;
  localparam int CLK_NS    = 10;
  // reset command recovery is a longest time: round down
  localparam int T_RR_NS   = 250;
  localparam int RR_CYC    = (T_RR_NS / CLK_NS < 1) ? 1 : T_RR_NS / CLK_NS;
  // idle hardware reset is a longest time: round down
  localparam int T_RDYI_NS = 500;
  localparam int RDYI_CYC  = (T_RDYI_NS / CLK_NS < 1) ? 1 : T_RDYI_NS / CLK_NS;
  // reset high to read is a least time: round up
  localparam int T_RH_NS   = 50;
  localparam int RH_CYC    = (T_RH_NS + CLK_NS - 1) / CLK_NS;

  localparam int AW   = 12;  // command address width
  localparam int MW   = 6;   // array word address width
  localparam int SW   = 3;   // sector index width
  localparam int NSEC = 8;
  localparam int CW   = 16;  // counter width

  localparam logic [AW-1:0] ADDR_UNLK1 = 12'h555;
  localparam logic [AW-1:0] ADDR_UNLK2 = 12'h2AA;
  localparam logic [7:0] CMD_UNLK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLK2 = 8'h55;
  localparam logic [7:0] CMD_PROG  = 8'hA0;
  localparam logic [7:0] CMD_ERS   = 8'h80;
  localparam logic [7:0] CMD_CHIP  = 8'h10;
  localparam logic [7:0] CMD_SECT  = 8'h30;  // also erase resume
  localparam logic [7:0] CMD_SUSP  = 8'hB0;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_IDENT = 8'h90;

  localparam int BIT_POLL = 7;
  localparam int BIT_TOG  = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_WIN  = 3;
  localparam int BIT_STOG = 2;

  localparam logic [2:0] CYC_RST = 3'h0;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001, ST_IDENT = 9'h002, ST_PROG = 9'h004,
    ST_EWIN  = 9'h008, ST_ERASE = 9'h010, ST_FAIL = 9'h020,
    ST_RCOV  = 9'h040, ST_HRST  = 9'h080, ST_RHW  = 9'h100
  } fws_state_t;

  typedef struct packed {
    logic [AW-1:0] address;
    logic          read;
    logic          write;
    logic [7:0]    writedata;
  } fws_avreq_t;

  typedef struct packed {
    fws_state_t                  state;
    logic [2:0]                  cyc;
    logic                        ers;
    logic                        susp;
    logic                        wasEmb;
    logic [CW-1:0]               cnt;
    logic [CW-1:0]               ecnt;
    logic [MW-1:0]               pAddr;
    logic [7:0]                  pData;
    logic [NSEC-1:0]             sel;
    logic                        tog;
    logic                        stog;
    logic                        ack;
    logic [7:0]                  rdata;
    logic [(1<<MW)-1:0][7:0]     mem;
  } fws_st_t;
endpackage

// >>> rtl/fws_flash_status.sv
// fws_flash_status: command decoder, embedded timers and status reads
// assumes an Avalon-MM master with 8-bit data and a synchronous reset pin
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module fws_flash_status #(
  parameter int WIN_CYC   = 5000,
  parameter int PROG_CYC  = 100,
  parameter int ERASE_CYC = 8000,
  parameter int RDYE_CYC  = 2000,
  parameter logic [7:0] IDENT_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire fws_pkg::fws_avreq_t avReq,
  output logic [7:0]              readdata,
  output logic                    waitrequest,
  input  wire logic               resetPinN,
  output logic                    readyBusyOut,
  output logic                    readyBusyOe
);
  fws_pkg::fws_st_t st;
  fws_pkg::fws_st_t next_st;
  logic             busy;
  logic             stall;
  logic             wrAcc;
  logic             rdAcc;
  logic             inSel;
  localparam int MW_LOC = fws_pkg::MW;
  logic [7:0]       wd;
  logic [MW_LOC-1:0] wa;

  // the bus address low bits pick a word; high bits of those pick a sector
  assign wd    = avReq.writedata;
  assign wa    = avReq.address[fws_pkg::MW-1:0];
  assign inSel = st.sel[wa[fws_pkg::MW-1 -: fws_pkg::SW]];
  assign wrAcc = st.ack & avReq.write;
  assign rdAcc = st.ack & avReq.read;
  // reads stall under the reset pin so no stale array data escapes
  assign stall = (st.state == fws_pkg::ST_HRST) | (st.state == fws_pkg::ST_RHW);
  assign waitrequest = (avReq.read | avReq.write) & ~st.ack;
  assign readdata    = st.rdata;

  // busy covers every embedded state and the reset recovery
  always_comb begin
    unique case (st.state)
      fws_pkg::ST_PROG, fws_pkg::ST_EWIN, fws_pkg::ST_ERASE,
      fws_pkg::ST_FAIL, fws_pkg::ST_RCOV: busy = 1'b1;
      fws_pkg::ST_HRST: busy = st.wasEmb & (st.cnt != '0);
      default: busy = 1'b0;
    endcase
  end
  // open drain: the level is always low, only the enable moves
  assign readyBusyOut = 1'b0;
  assign readyBusyOe  = busy;

  // one process holds the whole next-state function
  always_comb begin
    next_st = st;
    next_st.ack = (avReq.read | avReq.write) & ~st.ack & ~stall;
    // status word for the read answered at the next edge
    if (st.state == fws_pkg::ST_PROG || st.state == fws_pkg::ST_FAIL) begin
      next_st.rdata = '0;
      next_st.rdata[fws_pkg::BIT_POLL] = ~st.pData[7];
      next_st.rdata[fws_pkg::BIT_TOG]  = st.tog;
      next_st.rdata[fws_pkg::BIT_FAIL] = (st.state == fws_pkg::ST_FAIL);
    end else if (st.state == fws_pkg::ST_EWIN || st.state == fws_pkg::ST_ERASE) begin
      next_st.rdata = '0;
      next_st.rdata[fws_pkg::BIT_TOG]  = st.tog;
      next_st.rdata[fws_pkg::BIT_WIN]  = (st.state == fws_pkg::ST_ERASE);
      next_st.rdata[fws_pkg::BIT_STOG] = st.stog & inSel;
    end else if (st.state == fws_pkg::ST_IDLE && st.susp && inSel) begin
      next_st.rdata = '0;
      next_st.rdata[fws_pkg::BIT_POLL] = 1'b1;
      next_st.rdata[fws_pkg::BIT_STOG] = st.stog;
    end else if (st.state == fws_pkg::ST_IDENT) begin
      next_st.rdata = IDENT_CODE;
    end else begin
      next_st.rdata = st.mem[wa];
    end
    // toggles advance once per answered read
    if (rdAcc) begin
      if (busy && st.state != fws_pkg::ST_RCOV && st.state != fws_pkg::ST_HRST) begin
        next_st.tog = ~st.tog;
      end
      if ((st.state == fws_pkg::ST_ERASE || st.state == fws_pkg::ST_EWIN ||
           (st.state == fws_pkg::ST_IDLE && st.susp)) && inSel) begin
        next_st.stog = ~st.stog;
      end
    end
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    unique case (st.state)
      fws_pkg::ST_IDLE, fws_pkg::ST_IDENT: begin
        if (wrAcc) begin
          next_st.cyc = fws_pkg::CYC_RST;
          if (wd == fws_pkg::CMD_RESET) begin
            // address ignored; suspend flag survives into recovery
            next_st.ers   = 1'b0;
            next_st.state = fws_pkg::ST_RCOV;
            // one short: the load edge counts, so recovery ends inside the limit
            next_st.cnt   = fws_pkg::CW'(fws_pkg::RR_CYC - 1);
          end else if (st.state == fws_pkg::ST_IDENT) begin
            next_st.cyc = fws_pkg::CYC_RST;
          end else if (st.susp && st.cyc == 3'h0 && wd == fws_pkg::CMD_SECT) begin
            next_st.susp  = 1'b0;
            next_st.state = fws_pkg::ST_ERASE;
          end else begin
            unique case (st.cyc)
              3'h0: if (wd == fws_pkg::CMD_UNLK1 &&
                        avReq.address == fws_pkg::ADDR_UNLK1) begin
                next_st.cyc = 3'h1;
              end else begin
                next_st.ers = 1'b0;
              end
              3'h1: if (wd == fws_pkg::CMD_UNLK2 &&
                        avReq.address == fws_pkg::ADDR_UNLK2) begin
                next_st.cyc = 3'h2;
              end else begin
                next_st.ers = 1'b0;
              end
              3'h2: begin
                next_st.ers = 1'b0;
                if (st.ers && wd == fws_pkg::CMD_CHIP &&
                    avReq.address == fws_pkg::ADDR_UNLK1) begin
                  next_st.sel   = '1;
                  next_st.state = fws_pkg::ST_ERASE;
                  next_st.ecnt  = fws_pkg::CW'(ERASE_CYC);
                end else if (st.ers && wd == fws_pkg::CMD_SECT) begin
                  next_st.sel = '0;
                  next_st.sel[wa[fws_pkg::MW-1 -: fws_pkg::SW]] = 1'b1;
                  next_st.state = fws_pkg::ST_EWIN;
                  next_st.cnt   = fws_pkg::CW'(WIN_CYC);
                end else if (avReq.address != fws_pkg::ADDR_UNLK1) begin
                  next_st.cyc = fws_pkg::CYC_RST;
                end else if (wd == fws_pkg::CMD_PROG) begin
                  next_st.cyc = 3'h3;
                end else if (wd == fws_pkg::CMD_ERS && !st.susp) begin
                  next_st.ers = 1'b1;
                end else if (wd == fws_pkg::CMD_IDENT) begin
                  next_st.state = fws_pkg::ST_IDENT;
                end
              end
              default: begin
                // fourth write carries the program address and data
                next_st.pAddr = wa;
                next_st.pData = wd;
                next_st.state = fws_pkg::ST_PROG;
                next_st.cnt   = fws_pkg::CW'(PROG_CYC);
              end
            endcase
          end
        end
      end
      fws_pkg::ST_PROG: begin
        // reset and other commands are ignored once programming runs
        if (st.cnt == '0) begin
          if ((st.pData & ~st.mem[st.pAddr]) != 8'h00) begin
            next_st.state = fws_pkg::ST_FAIL;
          end else begin
            next_st.mem[st.pAddr] = st.pData;
            next_st.state = fws_pkg::ST_IDLE;
          end
        end
      end
      fws_pkg::ST_EWIN: begin
        if (wrAcc && wd == fws_pkg::CMD_SECT) begin
          next_st.sel[wa[fws_pkg::MW-1 -: fws_pkg::SW]] = 1'b1;
          next_st.cnt = fws_pkg::CW'(WIN_CYC);
        end else if (st.cnt == '0) begin
          next_st.state = fws_pkg::ST_ERASE;
          next_st.ecnt  = fws_pkg::CW'(ERASE_CYC);
        end
      end
      fws_pkg::ST_ERASE: begin
        // suspend freezes the remaining count; resume picks it up where it stopped
        if (wrAcc && wd == fws_pkg::CMD_SUSP) begin
          next_st.susp  = 1'b1;
          next_st.state = fws_pkg::ST_IDLE;
        end else if (st.ecnt != '0) begin
          next_st.ecnt = st.ecnt - 1'b1;
        end else begin
          for (int i = 0; i < (1 << fws_pkg::MW); i++) begin
            if (st.sel[i >> (fws_pkg::MW - fws_pkg::SW)]) begin
              next_st.mem[i] = 8'hFF;
            end
          end
          next_st.sel   = '0;
          next_st.state = fws_pkg::ST_IDLE;
        end
      end
      fws_pkg::ST_FAIL: begin
        if (wrAcc && wd == fws_pkg::CMD_RESET) begin
          next_st.state = fws_pkg::ST_RCOV;
          next_st.cnt   = fws_pkg::CW'(fws_pkg::RR_CYC - 1);
        end
      end
      fws_pkg::ST_RCOV: begin
        if (st.cnt == '0) begin
          next_st.state = fws_pkg::ST_IDLE;
          next_st.cyc   = fws_pkg::CYC_RST;
        end
      end
      fws_pkg::ST_HRST: begin
        // the ready time runs out before the pin is honoured; the bus stays stalled
        if (resetPinN && st.cnt == '0) begin
          next_st.state = fws_pkg::ST_RHW;
          next_st.cnt   = fws_pkg::CW'(fws_pkg::RH_CYC);
        end
      end
      fws_pkg::ST_RHW: begin
        if (st.cnt == '0) begin
          next_st.state = fws_pkg::ST_IDLE;
        end
      end
    endcase
    // the pin wins over everything; busy at entry picks the ready time
    if (!resetPinN && st.state != fws_pkg::ST_HRST) begin
      next_st.state  = fws_pkg::ST_HRST;
      next_st.wasEmb = busy;
      next_st.cnt    = busy ? fws_pkg::CW'(RDYE_CYC)
                            : fws_pkg::CW'(fws_pkg::RDYI_CYC);
      next_st.susp   = 1'b0;
      next_st.sel    = '0;
      next_st.cyc    = fws_pkg::CYC_RST;
      next_st.ers    = 1'b0;
    end
  end

  // array contents are left untouched by reset, like real cells
  always_ff @(posedge mclk) begin
    if (reset) begin
      st       <= '0;
      st.state <= fws_pkg::ST_IDLE;
      st.mem   <= st.mem;
    end else begin
      st <= next_st;
    end
  end

  // status and busy checks, one clock domain, quiet under reset
  a_prog_busy: assert property (@(posedge mclk) disable iff (reset)
    st.state == fws_pkg::ST_PROG |-> readyBusyOe)
    else $error("busy released while programming");
  a_fail_flag: assert property (@(posedge mclk) disable iff (reset)
    st.ack && $past(st.state == fws_pkg::ST_FAIL) && $past(avReq.read)
    |-> readdata[fws_pkg::BIT_FAIL])
    else $error("failure flag not shown");
  a_win_flag: assert property (@(posedge mclk) disable iff (reset)
    st.ack && $past(avReq.read) && $past(st.state == fws_pkg::ST_EWIN)
    |-> !readdata[fws_pkg::BIT_WIN] && !readdata[fws_pkg::BIT_POLL])
    else $error("window flag set during window");
  a_erase_poll: assert property (@(posedge mclk) disable iff (reset)
    st.ack && $past(avReq.read) && $past(st.state == fws_pkg::ST_ERASE)
    |-> readdata[fws_pkg::BIT_WIN] && !readdata[fws_pkg::BIT_POLL])
    else $error("erase status wrong");
  a_tog_flip: assert property (@(posedge mclk) disable iff (reset)
    rdAcc && st.state == fws_pkg::ST_PROG |=> st.tog != $past(st.tog))
    else $error("toggle bit stuck");
  a_prog_start: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && resetPinN && st.state == fws_pkg::ST_IDLE && st.cyc == 3'h3
    && wd != fws_pkg::CMD_RESET |=> st.state == fws_pkg::ST_PROG ##0 readyBusyOe)
    else $error("program did not start");
  a_chip_nowin: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && resetPinN && st.state == fws_pkg::ST_IDLE && st.cyc == 3'h2 && st.ers
    && wd == fws_pkg::CMD_CHIP && avReq.address == fws_pkg::ADDR_UNLK1
    |=> st.state == fws_pkg::ST_ERASE)
    else $error("chip erase went through window");
  a_erase_rst: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && resetPinN && st.state == fws_pkg::ST_ERASE && wd == fws_pkg::CMD_RESET
    && st.ecnt != '0 |=> st.state == fws_pkg::ST_ERASE)
    else $error("reset ended erase");
  a_susp_free: assert property (@(posedge mclk) disable iff (reset)
    st.state == fws_pkg::ST_IDLE && st.susp |-> !readyBusyOe)
    else $error("busy in suspend");
  a_rr_time: assert property (@(posedge mclk) disable iff (reset)
    st.state == fws_pkg::ST_FAIL && wrAcc && resetPinN && wd == fws_pkg::CMD_RESET
    |-> ##[1:26] st.state == fws_pkg::ST_IDLE)
    else $error("reset recovery too long");

  // mode and reset handling
  a_ident_hold: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && resetPinN && st.state == fws_pkg::ST_IDENT && wd != fws_pkg::CMD_RESET
    |=> st.state == fws_pkg::ST_IDENT)
    else $error("identify left without reset");
  a_rst_cmd: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && resetPinN && st.state == fws_pkg::ST_IDLE && wd == fws_pkg::CMD_RESET
    |=> st.state == fws_pkg::ST_RCOV && st.susp == $past(st.susp))
    else $error("reset command mishandled");
  a_win_restart: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && resetPinN && st.state == fws_pkg::ST_EWIN && wd == fws_pkg::CMD_SECT
    |=> st.state == fws_pkg::ST_EWIN && st.cnt == fws_pkg::CW'(WIN_CYC))
    else $error("window not restarted");
  a_busy_reject: assert property (@(posedge mclk) disable iff (reset)
    wrAcc && resetPinN && st.state == fws_pkg::ST_ERASE && wd != fws_pkg::CMD_SUSP
    && st.ecnt != '0 |=> st.state == fws_pkg::ST_ERASE)
    else $error("command taken while erasing");
  a_stog_move: assert property (@(posedge mclk) disable iff (reset)
    rdAcc && st.state == fws_pkg::ST_IDLE && st.susp && inSel
    |=> st.stog != $past(st.stog))
    else $error("sector toggle stuck in suspend");
  a_pin_busy: assert property (@(posedge mclk) disable iff (reset)
    readyBusyOe && !resetPinN && st.state != fws_pkg::ST_HRST
    |=> st.state == fws_pkg::ST_HRST && readyBusyOe)
    else $error("busy dropped at reset pin");
  a_pin_stall: assert property (@(posedge mclk) disable iff (reset)
    st.state == fws_pkg::ST_HRST || st.state == fws_pkg::ST_RHW |=> !st.ack)
    else $error("bus answered under reset pin");

  // covers for the main paths through programming, erase, identify and reset
  c_prog_done: cover property (@(posedge mclk)
    st.state == fws_pkg::ST_PROG ##1 st.state == fws_pkg::ST_IDLE);
  c_fail: cover property (@(posedge mclk) st.state == fws_pkg::ST_FAIL);
  c_susp: cover property (@(posedge mclk) st.state == fws_pkg::ST_IDLE && st.susp);
  c_ident: cover property (@(posedge mclk) st.state == fws_pkg::ST_IDENT);
  c_pin_emb: cover property (@(posedge mclk) st.state == fws_pkg::ST_HRST && st.wasEmb);
endmodule

// >>> dv/fws_host_model.sv
// fws_host_model: host memory controller that issues command cycles and status reads
// assumes the sequencer answers every Avalon request by dropping waitrequest
`timescale 1ns/1ps
module fws_host_model (
  input  wire logic            mclk,
  input  wire logic [7:0]      readdata,
  input  wire logic            waitrequest,
  input  wire logic            readyBusyOut,
  input  wire logic            readyBusyOe,
  output fws_pkg::fws_avreq_t  avReq,
  output logic                 rbLine
);
  // shared line with a pull-up: a released driver reads high, never the last value
  assign rbLine = readyBusyOe ? readyBusyOut : 1'b1;

  initial avReq = '0;

  // one bus cycle: request held until waitrequest is sampled low, data taken there
  task automatic xfer(input logic [fws_pkg::AW-1:0] a, input logic rd, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    avReq <= '{address: a, read: rd, write: !rd, writedata: d};
    do @(posedge mclk); while (waitrequest !== 1'b0);
    q = readdata;
    avReq <= '0;
  endtask

  task automatic wr(input logic [fws_pkg::AW-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b0, d, q);
  endtask

  task automatic rd(input logic [fws_pkg::AW-1:0] a, output logic [7:0] q);
    xfer(a, 1'b1, 8'h00, q);
  endtask

  // bounded wait for the line to be released; the count tells how long it was held
  task automatic wait_rdy(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rbLine !== 1'b1 && n < 2000);
  endtask
endmodule

// >>> dv/tb.sv
// tb: command sequences against the flash write-status sequencer, shortened timers
// assumes the host model holds the bus tasks and the pulled-up ready-busy line
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb;
  localparam int WIN = 20;
  localparam int PROG = 10;
  localparam int RDYE = 20;
  localparam logic [7:0] IDC = 8'hC3;  // arbitrary value
  logic                    mclk = 1'b0;
  logic                    reset = 1'b1;
  logic                    resetPinN = 1'b1;
  fws_pkg::fws_avreq_t     avReq;
  logic [7:0]              readdata;
  logic                    waitrequest;
  logic                    readyBusyOut;
  logic                    readyBusyOe;
  logic                    rbLine;
  int                      n_mismatch = 0;
  int                      samples_checked = 0;
  int                      cycles = 0;
  logic [11:0]             pa [2] = '{12'h005, 12'h009};
  logic [7:0]              pd [2] = '{8'h3C, 8'h00};

  fws_flash_status #(.WIN_CYC(WIN), .PROG_CYC(PROG), .ERASE_CYC(30), .RDYE_CYC(RDYE),
    .IDENT_CODE(IDC)) dut (.mclk(mclk), .reset(reset), .avReq(avReq), .readdata(readdata),
    .waitrequest(waitrequest), .resetPinN(resetPinN), .readyBusyOut(readyBusyOut),
    .readyBusyOe(readyBusyOe));
  fws_host_model host (.mclk(mclk), .readdata(readdata), .waitrequest(waitrequest),
    .readyBusyOut(readyBusyOut), .readyBusyOe(readyBusyOe), .avReq(avReq), .rbLine(rbLine));

  always #5 mclk = ~mclk;

  // cut a hang short well past the longest expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic unlock();
    host.wr(fws_pkg::ADDR_UNLK1, fws_pkg::CMD_UNLK1);
    host.wr(fws_pkg::ADDR_UNLK2, fws_pkg::CMD_UNLK2);
  endtask

  task automatic prog(input logic [11:0] a, input logic [7:0] d);
    unlock();
    host.wr(fws_pkg::ADDR_UNLK1, fws_pkg::CMD_PROG);
    host.wr(a, d);
  endtask

  task automatic erase6(input logic [11:0] a, input logic [7:0] c);
    unlock();
    host.wr(fws_pkg::ADDR_UNLK1, fws_pkg::CMD_ERS);
    unlock();
    host.wr(a, c);
  endtask

  initial begin
    logic [7:0] q;
    logic [7:0] q2;
    int n;
    int c0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK(rbLine, 1'b1)
    // chip erase: busy at once, no window, ones restored
    erase6(fws_pkg::ADDR_UNLK1, fws_pkg::CMD_CHIP);
    @(posedge mclk);
    `CHK(readyBusyOe, 1'b1)
    host.rd(12'h005, q);
    host.rd(12'h005, q2);
    `CHK(q[fws_pkg::BIT_POLL], 1'b0)
    `CHK(q[fws_pkg::BIT_TOG] ^ q2[fws_pkg::BIT_TOG], 1'b1)
    `CHK(q[fws_pkg::BIT_WIN], 1'b1)
    `CHK(q[fws_pkg::BIT_FAIL], 1'b0)
    host.wait_rdy(n);
    host.rd(12'h005, q);
    `CHK(q, 8'hFF)
    // two programs, status while running, then data
    for (int i = 0; i < 2; i++) begin
      prog(pa[i], pd[i]);
      @(posedge mclk);
      `CHK(rbLine, 1'b0)
      host.rd(pa[i], q);
      host.rd(pa[i], q2);
      `CHK(q[fws_pkg::BIT_POLL], ~pd[i][7])
      `CHK(q[fws_pkg::BIT_TOG] ^ q2[fws_pkg::BIT_TOG], 1'b1)
      `CHK(q[fws_pkg::BIT_STOG] ^ q2[fws_pkg::BIT_STOG], 1'b0)
      host.wait_rdy(n);
      host.rd(pa[i], q);
      `CHK(q, pd[i])
    end
    // a zero bit asked to become one ends in failure; reset command recovers
    prog(12'h005, 8'hFF);
    repeat (PROG + 5) @(posedge mclk);
    host.rd(12'h005, q);
    `CHK(q[fws_pkg::BIT_FAIL], 1'b1)
    host.wr(12'h7E3, fws_pkg::CMD_RESET);
    host.wait_rdy(n);
    `CHK(n <= fws_pkg::RR_CYC + 1, 1'b1)
    host.rd(12'h005, q);
    `CHK(q, 8'h3C)
    // reset inside a program sequence aborts it; the lone data write is ignored
    unlock();
    host.wr(fws_pkg::ADDR_UNLK1, fws_pkg::CMD_PROG);
    host.wr(12'h000, fws_pkg::CMD_RESET);
    host.wait_rdy(n);
    host.wr(12'h005, 8'h00);
    @(posedge mclk);
    `CHK(readyBusyOe, 1'b0)
    // reset interleaved in identify entry, then full entry and exit
    unlock();
    host.wr(12'h000, fws_pkg::CMD_RESET);
    host.wait_rdy(n);
    host.wr(fws_pkg::ADDR_UNLK1, fws_pkg::CMD_IDENT);
    host.rd(12'h005, q);
    `CHK(q, 8'h3C)
    unlock();
    host.wr(fws_pkg::ADDR_UNLK1, fws_pkg::CMD_IDENT);
    host.rd(12'h000, q);
    `CHK(q, IDC)
    host.wr(12'h000, fws_pkg::CMD_RESET);
    host.wait_rdy(n);
    host.rd(12'h005, q);
    `CHK(q, 8'h3C)
    // sector erase with a second sector, ignored reset, suspend and resume
    erase6(12'h008, fws_pkg::CMD_SECT);
    @(posedge mclk);
    `CHK(readyBusyOe, 1'b1)
    host.rd(12'h008, q);
    `CHK(q[fws_pkg::BIT_WIN], 1'b0)
    host.wr(12'h010, fws_pkg::CMD_SECT);
    c0 = cycles;
    host.rd(12'h010, q);
    `CHK(q[fws_pkg::BIT_WIN], 1'b0)
    do host.rd(12'h008, q); while (q[fws_pkg::BIT_WIN] !== 1'b1 && cycles - c0 < 200);
    `CHK(cycles - c0 >= WIN - 2 && cycles - c0 <= WIN + 10, 1'b1)
    host.wr(12'h000, fws_pkg::CMD_RESET);
    host.rd(12'h008, q);
    `CHK(q[fws_pkg::BIT_POLL], 1'b0)
    host.wr(12'h008, fws_pkg::CMD_SUSP);
    repeat (2) @(posedge mclk);
    `CHK(rbLine, 1'b1)
    host.rd(12'h008, q);
    host.rd(12'h008, q2);
    `CHK(q[fws_pkg::BIT_POLL], 1'b1)
    `CHK(q[fws_pkg::BIT_TOG] ^ q2[fws_pkg::BIT_TOG], 1'b0)
    `CHK(q[fws_pkg::BIT_STOG] ^ q2[fws_pkg::BIT_STOG], 1'b1)
    host.rd(12'h005, q);
    `CHK(q, 8'h3C)
    // the added sector is suspended too, so it gives status with a still toggle bit
    host.rd(12'h010, q);
    `CHK(q[fws_pkg::BIT_TOG], 1'b0)
    host.wr(12'h008, fws_pkg::CMD_SECT);
    @(posedge mclk);
    `CHK(readyBusyOe, 1'b1)
    host.wait_rdy(n);
    host.rd(12'h009, q);
    `CHK(q, 8'hFF)
    host.rd(12'h005, q);
    `CHK(q, 8'h3C)
    // hardware reset during a program keeps the line low for the embedded ready time
    prog(12'h00A, 8'h11);
    resetPinN <= 1'b0;
    repeat (3) @(posedge mclk);
    resetPinN <= 1'b1;
    host.wait_rdy(n);
    `CHK(n >= RDYE - 5, 1'b1)
    // idle hardware reset: reads stall until the idle ready time has run out and then the pin has been high long enough
    @(posedge mclk);
    resetPinN <= 1'b0;
    repeat (5) @(posedge mclk);
    resetPinN <= 1'b1;
    c0 = cycles;
    host.rd(12'h005, q);
    `CHK(cycles - c0 >= fws_pkg::RH_CYC, 1'b1)
    `CHK(q, 8'h3C)
    stop_test();
  end
endmodule
